// >>> verilog/uft_frame_timer.sv
// Frame timer of a full-speed USB host controller with AXI4-Lite access.
`timescale 1ns/100ps
module uft_frame_timer
	import uft_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic transaction_busy,
	output logic frame_start,
	output logic periodic_priority,
	output logic [PKT_W-1:0] largest_packet_count,
	output logic [FN_W-1:0] frame_sequence_count
);

	// ----------------------------------------------------------------
	// Bit-time enable
	// ----------------------------------------------------------------
	logic tick;

	uft_bit_tick u_tick (
		.aclk(aclk),
		.aresetn(aresetn),
		.tick(tick)
	);

	// ----------------------------------------------------------------
	// Bus write path
	// ----------------------------------------------------------------
	logic aw_held_q;
	logic w_held_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic wr_go;
	logic wr_mapped;

	assign awready = !aw_held_q && !bvalid_q;
	assign wready = !w_held_q && !bvalid_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign wr_go = aw_held_q && w_held_q;
	assign wr_mapped = awaddr_q == ADDR_CONTROL ||
		awaddr_q == ADDR_COMMAND || awaddr_q == ADDR_FRAME_LENGTH ||
		awaddr_q == ADDR_FRAME_REMAIN || awaddr_q == ADDR_FRAME_NUMBER ||
		awaddr_q == ADDR_PERIODIC;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			awaddr_q <= '0;
		end else if (awvalid && awready) begin
			aw_held_q <= 1'b1;
			awaddr_q <= awaddr;
		end else if (wr_go) begin
			aw_held_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_q <= 1'b0;
			wdata_q <= '0;
			wstrb_q <= '0;
		end else if (wvalid && wready) begin
			w_held_q <= 1'b1;
			wdata_q <= wdata;
			wstrb_q <= wstrb;
		end else if (wr_go) begin
			w_held_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end else if (wr_go) begin
			bvalid_q <= 1'b1;
			bresp_q <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
		end else if (bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Software-written registers
	// ----------------------------------------------------------------
	logic [31:0] len_word;
	logic [31:0] cmd_word;
	logic [31:0] ctl_word;
	logic [31:0] per_word;
	logic wr_len;
	logic soft_reset;
	logic length_toggle_q;
	logic [PKT_W-1:0] largest_packet_bits_q;
	logic [LEN_W-1:0] nominal_frame_length_q;
	logic [LEN_W-1:0] periodic_threshold_q;
	uft_run_type run_q;

	logic [31:0] len_merged;
	logic [31:0] per_merged;

	assign len_word = uft_merge(32'h0000_0000, wdata_q, wstrb_q);
	assign len_merged = uft_merge({length_toggle_q, largest_packet_bits_q,
		2'h0, nominal_frame_length_q}, wdata_q, wstrb_q);
	assign per_merged = uft_merge({18'h00000, periodic_threshold_q},
		wdata_q, wstrb_q);
	assign cmd_word = len_word;
	assign ctl_word = len_word;
	assign per_word = len_word;
	assign wr_len = wr_go && awaddr_q == ADDR_FRAME_LENGTH;
	assign soft_reset = wr_go && awaddr_q == ADDR_COMMAND &&
		wstrb_q[0] && cmd_word[SOFT_RESET_BIT];

	// Untouched byte lanes keep their old value
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			length_toggle_q <= 1'b0;
			largest_packet_bits_q <= PKT_RESET;
			nominal_frame_length_q <= NOMINAL_FRAME_LEN;
		end else if (soft_reset) begin
			nominal_frame_length_q <= NOMINAL_FRAME_LEN;
		end else if (wr_len) begin
			length_toggle_q <= len_merged[TOGGLE_BIT];
			largest_packet_bits_q <= len_merged[PKT_MSB:PKT_LSB];
			nominal_frame_length_q <= len_merged[LEN_MSB:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			periodic_threshold_q <= PERIODIC_RESET;
		end else if (wr_go && awaddr_q == ADDR_PERIODIC) begin
			periodic_threshold_q <= per_merged[LEN_MSB:0];
		end
	end

	// Soft reset also drops the controller out of operation
	always_ff @(posedge aclk) begin
		if (!aresetn || soft_reset) begin
			run_q <= RUN_HALTED;
		end else if (wr_go && awaddr_q == ADDR_CONTROL && wstrb_q[0]) begin
			run_q <= ctl_word[OPER_BIT] ? RUN_OPERATIONAL : RUN_HALTED;
		end
	end

	// ----------------------------------------------------------------
	// Frame counters
	// ----------------------------------------------------------------
	logic [LEN_W-1:0] bit_time_countdown_q;
	logic countdown_toggle_q;
	logic [FN_W-1:0] frame_sequence_count_q;
	logic [PKT_W-1:0] packet_count_q;
	logic frame_start_q;
	logic run_prev_q;
	logic running;
	logic enter;
	logic reload;

	assign running = run_q == RUN_OPERATIONAL;
	assign enter = running && !run_prev_q;
	assign reload = running && tick && bit_time_countdown_q == '0;
	assign frame_start = frame_start_q;
	assign frame_sequence_count = frame_sequence_count_q;
	assign largest_packet_count = packet_count_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			run_prev_q <= 1'b0;
		end else begin
			run_prev_q <= running;
		end
	end

	// A new length only shows up at the next reload
	always_ff @(posedge aclk) begin
		if (!aresetn || soft_reset) begin
			bit_time_countdown_q <= '0;
		end else if (enter) begin
			bit_time_countdown_q <= nominal_frame_length_q;
		end else if (reload) begin
			bit_time_countdown_q <= nominal_frame_length_q;
		end else if (running && tick) begin
			bit_time_countdown_q <= bit_time_countdown_q - 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || soft_reset) begin
			countdown_toggle_q <= 1'b0;
		end else if (running && tick && !enter &&
				bit_time_countdown_q == LEN_W'(1)) begin
			countdown_toggle_q <= length_toggle_q;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || soft_reset) begin
			frame_sequence_count_q <= '0;
		end else if (enter || reload) begin
			frame_sequence_count_q <= frame_sequence_count_q + 1'b1;
		end
	end

	// Budget counter spends one bit per bit time within the frame
	always_ff @(posedge aclk) begin
		if (!aresetn || soft_reset) begin
			packet_count_q <= '0;
			frame_start_q <= 1'b0;
		end else if (enter || reload) begin
			packet_count_q <= largest_packet_bits_q;
			frame_start_q <= 1'b1;
		end else begin
			frame_start_q <= 1'b0;
			if (running && tick && packet_count_q != '0) begin
				packet_count_q <= packet_count_q - 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Periodic priority
	// ----------------------------------------------------------------
	// Held pending so that a busy bulk transfer is never cut short
	logic periodic_pend_q;
	logic periodic_priority_q;

	assign periodic_priority = periodic_priority_q;

	always_ff @(posedge aclk) begin
		if (!aresetn || soft_reset || !running || enter || reload) begin
			periodic_pend_q <= 1'b0;
			periodic_priority_q <= 1'b0;
		end else begin
			if (bit_time_countdown_q == periodic_threshold_q) begin
				periodic_pend_q <= 1'b1;
			end
			if (periodic_pend_q && !transaction_busy) begin
				periodic_priority_q <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Bus read path
	// ----------------------------------------------------------------
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic [31:0] rd_word;
	logic rd_ok;

	assign arready = !rvalid_q;
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;

	always_comb begin
		rd_word = 32'h0000_0000;
		rd_ok = 1'b1;
		case (araddr)
			ADDR_CONTROL: rd_word[OPER_BIT] = running;
			ADDR_COMMAND: rd_word = 32'h0000_0000;
			ADDR_FRAME_LENGTH: rd_word = {length_toggle_q,
				largest_packet_bits_q, 2'h0, nominal_frame_length_q};
			ADDR_FRAME_REMAIN: rd_word = {countdown_toggle_q, 17'h00000,
				bit_time_countdown_q};
			ADDR_FRAME_NUMBER: rd_word = {16'h0000, frame_sequence_count_q};
			ADDR_PERIODIC: rd_word = {18'h00000, periodic_threshold_q};
			default: rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid_q <= 1'b1;
			rdata_q <= rd_word;
			rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	tick_spacing_a: assert property (tick |=> !tick [*7])
		else $error("bit tick faster than 12 MHz");
	count_down_a: assert property (running && tick && !enter && !reload &&
		!soft_reset |=> bit_time_countdown_q ==
		$past(bit_time_countdown_q) - 14'h0001)
		else $error("countdown did not step by one");
	reload_length_a: assert property (reload && !soft_reset |=>
		bit_time_countdown_q == $past(nominal_frame_length_q))
		else $error("countdown not reloaded after zero");
	enter_reload_a: assert property (enter && !soft_reset |=>
		bit_time_countdown_q == $past(nominal_frame_length_q))
		else $error("countdown not loaded on entry");
	toggle_copy_a: assert property (running && tick && !enter &&
		!soft_reset && bit_time_countdown_q == 14'h0001 |=>
		bit_time_countdown_q == '0 &&
		countdown_toggle_q == $past(length_toggle_q))
		else $error("countdown toggle not copied");
	packet_load_a: assert property (frame_start_q |->
		packet_count_q == $past(largest_packet_bits_q))
		else $error("packet budget not loaded at frame start");
	frame_count_a: assert property ((enter || reload) && !soft_reset |=>
		frame_sequence_count_q == $past(frame_sequence_count_q) +
		16'h0001 && frame_start_q)
		else $error("frame count not advanced");
	soft_reset_a: assert property (soft_reset |=>
		nominal_frame_length_q == NOMINAL_FRAME_LEN && !running)
		else $error("soft reset left frame length changed");
	periodic_wait_a: assert property (periodic_pend_q && transaction_busy
		&& !periodic_priority_q |=> !periodic_priority_q)
		else $error("periodic priority cut a transaction");

	frame_seen_c: cover property (reload ##1 frame_start_q);
	soft_reset_c: cover property (wr_len ##[1:50] soft_reset);
	periodic_c: cover property (periodic_pend_q && transaction_busy
		##[1:20] periodic_priority_q);
	retrim_c: cover property (frame_start_q ##[1:20] wr_len);

endmodule

// >>> verilog/uft_pkg.sv
// Constants, field layout and helpers for the USB frame timer block.
package uft_pkg;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CONTROL = 8'h04;
	localparam logic [7:0] ADDR_COMMAND = 8'h08;
	localparam logic [7:0] ADDR_FRAME_LENGTH = 8'h34;
	localparam logic [7:0] ADDR_FRAME_REMAIN = 8'h38;
	localparam logic [7:0] ADDR_FRAME_NUMBER = 8'h3c;
	localparam logic [7:0] ADDR_PERIODIC = 8'h40;

	// ----------------------------------------------------------------
	// Field widths and positions
	// ----------------------------------------------------------------
	localparam int LEN_W = 14;
	localparam int PKT_W = 15;
	localparam int FN_W = 16;
	localparam int TOGGLE_BIT = 31;
	localparam int PKT_LSB = 16;
	localparam int PKT_MSB = 30;
	localparam int LEN_MSB = 13;
	localparam int OPER_BIT = 0;
	localparam int SOFT_RESET_BIT = 0;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	// 11,999, so a frame lasts 12,000 bit times
	localparam logic [13:0] NOMINAL_FRAME_LEN = 14'h2edf;
	localparam logic [14:0] PKT_RESET = 15'h0000;
	localparam logic [13:0] PERIODIC_RESET = 14'h0000;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_FREQ_MHZ = 100;
	localparam int BIT_RATE_MHZ = 12;
	localparam int ACC_W = 7;
	localparam logic [6:0] TICK_STEP = 7'(BIT_RATE_MHZ);
	localparam logic [6:0] TICK_MOD = 7'(CLK_FREQ_MHZ);

	// ----------------------------------------------------------------
	// Bus answers
	// ----------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic {
		RUN_HALTED,
		RUN_OPERATIONAL
	} uft_run_type;

	// Byte-lane merge of a write into a stored word
	function automatic logic [31:0] uft_merge(
		input logic [31:0] old,
		input logic [31:0] wdata,
		input logic [3:0] strb
	);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = wdata[i*8 +: 8];
			end
		end
		return res;
	endfunction

endpackage

// >>> verilog/uft_bit_tick.sv
// Fractional divider making the full-speed bit-time enable.
`timescale 1ns/100ps
module uft_bit_tick
	import uft_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	output logic tick
);

	// ----------------------------------------------------------------
	// Phase accumulator
	// ----------------------------------------------------------------
	// 12 of every 100 cycles tick; spacing jitters 8 or 9 cycles,
	// exact on average, which no integer divider could give.
	logic [ACC_W-1:0] acc_q;
	logic [ACC_W-1:0] sum;
	logic tick_q;

	assign sum = acc_q + TICK_STEP;
	assign tick = tick_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			acc_q <= '0;
			tick_q <= 1'b0;
		end else if (sum >= TICK_MOD) begin
			acc_q <= sum - TICK_MOD;
			tick_q <= 1'b1;
		end else begin
			acc_q <= sum;
			tick_q <= 1'b0;
		end
	end

endmodule

// >>> verif/uft_frame_timer_tb.sv
// Self-checking bench for the USB frame timer over AXI4-Lite.
`timescale 1ns/100ps
module uft_frame_timer_tb;
	import uft_pkg::*;

	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic awvalid = 1'b0;
	logic awready;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic wvalid = 1'b0;
	logic wready;
	logic [1:0] bresp;
	logic bvalid;
	logic bready = 1'b0;
	logic [7:0] araddr = 8'h00;
	logic arvalid = 1'b0;
	logic arready;
	logic [31:0] rdata;
	logic [1:0] rresp;
	logic rvalid;
	logic rready = 1'b0;
	logic transaction_busy = 1'b1;
	logic frame_start;
	logic periodic_priority;
	logic [PKT_W-1:0] largest_packet_count;
	logic [FN_W-1:0] frame_sequence_count;
	int fails = 0;
	int num_checks = 0;

	always #5 aclk = ~aclk;

	uft_frame_timer dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .transaction_busy(transaction_busy),
		.frame_start(frame_start), .periodic_priority(periodic_priority),
		.largest_packet_count(largest_packet_count),
		.frame_sequence_count(frame_sequence_count));

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		if (fails == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Handshakes are judged at the negedge so the posedge sees settled values
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [1:0] r);
		logic aw_hs, w_hs, b_hs;
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		r = 2'h3;
		do begin
			@(negedge aclk);
			aw_hs = awvalid && awready;
			w_hs = wvalid && wready;
			b_hs = bvalid && bready;
			if (b_hs) r = bresp;
			@(posedge aclk);
			if (aw_hs) awvalid <= 1'b0;
			if (w_hs) wvalid <= 1'b0;
		end while (!b_hs);
		bready <= 1'b0;
	endtask

	task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		logic ar_hs, r_hs;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge aclk);
			ar_hs = arvalid && arready;
			r_hs = rvalid && rready;
			d = rdata;
			r = rresp;
			@(posedge aclk);
			if (ar_hs) arvalid <= 1'b0;
		end while (!r_hs);
		// Ready stays high between reads, so back-to-back calls never
		// drive it twice in one step
	endtask

	// Counts cycles up to the next frame start pulse
	task automatic wait_fs(output int cyc);
		cyc = 0;
		do begin
			@(negedge aclk);
			cyc++;
		end while (frame_start !== 1'b1 && cyc < 400);
		@(posedge aclk);
	endtask

	// ----------------------------------------------------------------
	// Register table cases
	// ----------------------------------------------------------------
	typedef struct {
		logic wr;
		logic [7:0] a;
		logic [31:0] d;
		logic [3:0] s;
		logic [1:0] bexp;
		logic [31:0] rexp;
		logic [1:0] rrexp;
	} uft_row_type;

	uft_row_type rows[12] = '{
		'{1'b0, 8'h34, 32'h0, 4'h0, 2'h0, 32'h00002edf, 2'h0},
		'{1'b0, 8'h38, 32'h0, 4'h0, 2'h0, 32'h00000000, 2'h0},
		'{1'b0, 8'h3c, 32'h0, 4'h0, 2'h0, 32'h00000000, 2'h0},
		'{1'b0, 8'h40, 32'h0, 4'h0, 2'h0, 32'h00000000, 2'h0},
		'{1'b0, 8'h04, 32'h0, 4'h0, 2'h0, 32'h00000000, 2'h0},
		'{1'b0, 8'h08, 32'h0, 4'h0, 2'h0, 32'h00000000, 2'h0},
		'{1'b1, 8'h34, 32'h80050014, 4'hf, 2'h0, 32'h80050014, 2'h0},
		'{1'b1, 8'h34, 32'h000000ff, 4'h1, 2'h0, 32'h800500ff, 2'h0},
		'{1'b1, 8'h34, 32'h80050014, 4'hf, 2'h0, 32'h80050014, 2'h0},
		'{1'b1, 8'h38, 32'hffffffff, 4'hf, 2'h0, 32'h00000000, 2'h0},
		'{1'b1, 8'h40, 32'h00000005, 4'hf, 2'h0, 32'h00000005, 2'h0},
		'{1'b1, 8'h50, 32'h12345678, 4'hf, 2'h2, 32'h00000000, 2'h2}
	};

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [1:0] r;
		logic [31:0] d;
		int c;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		foreach (rows[i]) begin
			if (rows[i].wr) begin
				axi_write(rows[i].a, rows[i].d, rows[i].s, r);
				check(r, rows[i].bexp);
			end
			axi_read(rows[i].a, d, r);
			check(d, rows[i].rexp);
			check(r, rows[i].rrexp);
		end
		// Entry to operational is a frame start with the budget loaded
		axi_write(ADDR_CONTROL, 32'h1, 4'hf, r);
		wait_fs(c);
		check(frame_sequence_count, 32'h1);
		check(largest_packet_count inside {15'h5, 15'h4}, 1'b1);
		// Length 20 gives 21 bit times of 8 or 9 clocks each
		wait_fs(c);
		check(c >= 168 && c <= 189, 1'b1);
		check(frame_sequence_count, 32'h2);
		axi_read(ADDR_FRAME_REMAIN, d, r);
		check(d[31], 1'b1);
		check(d[13:0] <= 14'd20, 1'b1);
		// New length with toggle flipped, as software must do
		axi_write(ADDR_FRAME_LENGTH, 32'h0005001e, 4'hf, r);
		wait_fs(c);
		wait_fs(c);
		check(c >= 248 && c <= 279, 1'b1);
		axi_read(ADDR_FRAME_REMAIN, d, r);
		check(d[31], 1'b0);
		// Threshold 5 passes near tick 25; busy holds off the priority
		repeat (226) @(posedge aclk);
		check(periodic_priority, 1'b0);
		transaction_busy <= 1'b0;
		repeat (3) @(posedge aclk);
		check(periodic_priority, 1'b1);
		wait_fs(c);
		repeat (2) @(posedge aclk);
		check(periodic_priority, 1'b0);
		// Soft reset keeps toggle and budget, restores nominal length
		axi_write(ADDR_COMMAND, 32'h1, 4'hf, r);
		axi_read(ADDR_FRAME_LENGTH, d, r);
		check(d, 32'h00052edf);
		axi_read(ADDR_CONTROL, d, r);
		check(d, 32'h0);
		check(frame_sequence_count, 32'h0);
		report_and_stop();
	end

	// ----------------------------------------------------------------
	// Watchdog
	// ----------------------------------------------------------------
	// The sequence needs about 1,000 clocks; allow ample margin
	initial begin
		repeat (20000) @(posedge aclk);
		fails++;
		report_and_stop();
	end

endmodule
